// file: inc/pmc_pkg.sv
// Constants, types and register map of the power-mode and reset controller
package pmc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_PCLK_EN  = 8'h04;
  localparam logic [7:0] ADDR_PCLK_DIV = 8'h08;
  localparam logic [7:0] ADDR_PLL      = 8'h0c;
  localparam logic [7:0] ADDR_CLK_DIV  = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_MEMMAP   = 8'h18;
  localparam logic [7:0] ADDR_CLK_SRC  = 8'h1c;
  // Field positions
  localparam int PLL_EN_BIT     = 0;
  localparam int PLL_CON_BIT    = 1;
  localparam int USB_DIV_LSB    = 8;
  localparam int STAT_BOD_BIT   = 0;
  localparam int STAT_LOCK_BIT  = 1;
  localparam int STAT_RSRC_LSB  = 2;
  localparam int STAT_STATE_LSB = 8;
  // Reset values
  localparam logic [1:0] CLK_SRC_IRC  = 2'h0;
  localparam logic [7:0] DIV_RST      = 8'h00;
  localparam logic [15:0] WAKE_CLKS   = 16'h0800;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Low-power modes selected by software
  typedef enum logic [1:0] {
    MODE_IDLE  = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_PDOWN = 2'h2,
    MODE_DPD   = 2'h3
  } pmc_mode_t;

  // Controller states, one-hot
  typedef enum logic [6:0] {
    ST_RESET = 7'h01,
    ST_RUN   = 7'h02,
    ST_IDLE  = 7'h04,
    ST_SLEEP = 7'h08,
    ST_PDOWN = 7'h10,
    ST_DPD   = 7'h20,
    ST_WAKE  = 7'h40
  } pmc_state_t;

  // Clock and power gates handed to the chip
  typedef struct packed {
    logic cpu_clk;
    logic mem_clk;
    logic bus_clk;
    logic periph_clk;
    logic main_osc;
    logic irc_out;
    logic irc_power;
    logic rtc_osc;
    logic pll_power;
    logic flash_power;
    logic pin_hold;
    logic core_power;
  } pmc_gates_t;
endpackage

// file: hw/pmc_ctrl.sv
// Power-mode, clock gating and reset release controller with AXI4-Lite
// Function
// - Four software-selectable low-power modes
// - Idle gates core, memory, bus clocks
// - Idle keeps peripherals; interrupt resumes execution
// - Sleep stops oscillator, all clocks, holds pins
// - Sleep gates RC output, keeps it powered
// - RTC oscillator runs through Sleep
// - Sleep entry turns PLL off, disconnected
// - Sleep entry zeroes CPU and USB dividers
// - Sleep ends on reset or clockless interrupt
// - Flash stays powered during Sleep
// - Per-peripheral clock gate and divider
// - Battery domain keeps RTC and RAM alive
// - RTC alarm output while main unpowered
// - Chip reset merges pin, watchdog, POR, brownout
// - Reset held until pin, osc, count, flash
// - Release restores defaults, boot vectors at zero
// - Brownout stage one interrupt and status bit
// - Brownout stage two holds reset while asserted
// - Vector area mapped to boot ROM or SRAM
// - Power-down wake and power-up run from RC oscillator
// - Power-down wake passes the wake-up timer
// - PLL off after reset; connect only locked
module pmc_ctrl
  import pmc_pkg::*;
#(
  parameter int         NPER      = 16,
  parameter logic [15:0] WAKE_CNT = WAKE_CLKS
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // AXI4-Lite write channels
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Processor and interrupt side
  input  wire logic              cpu_sleep_req,
  input  wire logic              irq_pending,
  input  wire logic              clockless_irq,
  input  wire logic              rtc_irq,
  // Reset sources and supervisors
  input  wire logic              reset_pin_n,
  input  wire logic              wdt_reset,
  input  wire logic              por_reset,
  input  wire logic              bod_stage1,
  input  wire logic              bod_stage2,
  // Clock sources and flash
  input  wire logic              main_osc_ok,
  input  wire logic              pll_lock,
  input  wire logic              flash_init_done,
  input  wire logic              rtc_alarm,
  // Clock, power and reset outputs
  output pmc_gates_t             gates,
  output logic [NPER-1:0]        periph_clk_en,
  output logic [2*NPER-1:0]      periph_clk_div,
  output logic [7:0]             cpu_clk_div,
  output logic [7:0]             usb_clk_div,
  output logic                   pll_power,
  output logic                   pll_connect,
  output logic [1:0]             clk_src_sel,
  output logic                   chip_reset,
  output logic                   brownout_irq,
  output logic                   vec_in_sram,
  output logic                   rtc_alarm_out
);

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  pmc_state_t        state;       // Controller state
  pmc_state_t        next_state;  // Next controller state
  logic [15:0]       wake_cnt;    // Wake-up timer
  logic [1:0]        mode_sel;    // Software mode choice
  logic [31:0]       pclk_en;     // Peripheral clock enables
  logic [31:0]       pclk_div;    // Peripheral dividers, 2 bits each
  logic [1:0]        pll_ctl;     // PLL enable and connect
  logic [15:0]       clk_div;     // CPU and USB dividers
  logic              memmap;      // Vector area in SRAM
  logic [1:0]        clk_src;     // Clock source select
  logic [3:0]        rst_cause;   // Sticky reset causes
  logic              aw_held;     // Write address captured
  logic              w_held;      // Write data captured
  logic [7:0]        aw_addr;     // Captured write address
  logic [31:0]       w_data;      // Captured write data
  logic [3:0]        w_strb;      // Captured byte enables

  // Reset source merge [pin, wdt, por, bod]
  wire [3:0] rst_src   = {bod_stage2, por_reset, wdt_reset,
                          ~reset_pin_n};
  wire       any_rst   = |rst_src;
  wire       in_reset  = (state == ST_RESET);
  wire       wake_done = (wake_cnt >= WAKE_CNT);
  wire       do_write  = aw_held & w_held & ~s_axi_bvalid;
  wire       rd_take   = s_axi_arvalid & s_axi_arready;
  wire       aw_take   = s_axi_awvalid & s_axi_awready;
  wire       w_take    = s_axi_wvalid & s_axi_wready;
  wire       b_stay    = s_axi_bvalid & ~s_axi_bready;  // Answer still up
  wire       entering_sleep = (state == ST_RUN) & cpu_sleep_req &
                              (mode_sel == MODE_SLEEP);
  wire       pll_ok    = pll_ctl[PLL_EN_BIT] & pll_ctl[PLL_CON_BIT]
                         & pll_lock;
  wire [31:0] status_word = {16'h0000, 1'b0, state,
                              2'b00, rst_cause,
                              pll_lock, bod_stage1};

  // Write decode
  wire wr_mode   = do_write & (aw_addr == ADDR_MODE);
  wire wr_pen    = do_write & (aw_addr == ADDR_PCLK_EN);
  wire wr_pdiv   = do_write & (aw_addr == ADDR_PCLK_DIV);
  wire wr_pll    = do_write & (aw_addr == ADDR_PLL);
  wire wr_div    = do_write & (aw_addr == ADDR_CLK_DIV);
  wire wr_stat   = do_write & (aw_addr == ADDR_STATUS);
  wire wr_map    = do_write & (aw_addr == ADDR_MEMMAP);
  wire wr_src    = do_write & (aw_addr == ADDR_CLK_SRC);
  wire wr_hit    = wr_mode | wr_pen | wr_pdiv | wr_pll | wr_div |
                   wr_stat | wr_map | wr_src;
  wire [31:0] wm = merge(32'h0, w_data, w_strb);

  // Read decode; unmapped addresses answer SLVERR with zero data
  wire [7:0] ra = s_axi_araddr;
  wire rd_hit = (ra == ADDR_MODE) | (ra == ADDR_PCLK_EN) |
                (ra == ADDR_PCLK_DIV) | (ra == ADDR_PLL) |
                (ra == ADDR_CLK_DIV) | (ra == ADDR_STATUS) |
                (ra == ADDR_MEMMAP) | (ra == ADDR_CLK_SRC);
  wire [31:0] rd_word =
    (ra == ADDR_MODE)     ? {30'h0, mode_sel} :
    (ra == ADDR_PCLK_EN)  ? pclk_en :
    (ra == ADDR_PCLK_DIV) ? pclk_div :
    (ra == ADDR_PLL)      ? {30'h0, pll_ctl} :
    (ra == ADDR_CLK_DIV)  ? {16'h0, clk_div} :
    (ra == ADDR_STATUS)   ? status_word :
    (ra == ADDR_MEMMAP)   ? {31'h0, memmap} :
    (ra == ADDR_CLK_SRC)  ? {30'h0, clk_src} : 32'h0;

  // Mode transitions; any reset source wins from every state
  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (!any_rst && main_osc_ok && wake_done && flash_init_done)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (cpu_sleep_req) begin
          case (mode_sel)
            MODE_IDLE:  next_state = ST_IDLE;
            MODE_SLEEP: next_state = ST_SLEEP;
            MODE_PDOWN: next_state = ST_PDOWN;
            default:    next_state = ST_DPD;
          endcase
        end
      end
      ST_IDLE: begin
        if (irq_pending) next_state = ST_RUN;
      end
      ST_SLEEP: begin
        // Only interrupts that work without clocks can end Sleep
        if (clockless_irq || rtc_irq) next_state = ST_RUN;
      end
      ST_PDOWN, ST_DPD: begin
        if (clockless_irq || rtc_irq) next_state = ST_WAKE;
      end
      ST_WAKE: begin
        if (main_osc_ok && wake_done) next_state = ST_RUN;
      end
      default: next_state = ST_RESET;
    endcase
    if (any_rst) next_state = ST_RESET;
  end

  // State register and wake-up timer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state    <= ST_RESET;
      wake_cnt <= 16'h0000;
    end else begin
      state <= next_state;
      // Counter restarts on every reset source and power-down exit
      if (any_rst || (state != ST_RESET && state != ST_WAKE))
        wake_cnt <= 16'h0000;
      else if (!wake_done)
        wake_cnt <= wake_cnt + 16'h0001;
    end
  end

  // Software registers; internal reset restores defaults
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_sel <= MODE_IDLE;
      pclk_en  <= 32'hffffffff;
      pclk_div <= 32'h00000000;
      pll_ctl  <= 2'h0;
      clk_div  <= 16'h0000;
      memmap   <= 1'b0;
      clk_src  <= CLK_SRC_IRC;
    end else if (in_reset) begin
      mode_sel <= MODE_IDLE;
      pclk_en  <= 32'hffffffff;
      pclk_div <= 32'h00000000;
      pll_ctl  <= 2'h0;
      clk_div  <= 16'h0000;
      memmap   <= 1'b0;
      clk_src  <= CLK_SRC_IRC;
    end else begin
      if (wr_mode) mode_sel <= wm[1:0];
      if (wr_pen)  pclk_en  <= merge(pclk_en, w_data, w_strb);
      if (wr_pdiv) pclk_div <= merge(pclk_div, w_data, w_strb);
      if (wr_map)  memmap   <= wm[0];
      if (wr_src)  clk_src  <= wm[1:0];
      // Sleep entry overrides software: PLL off, dividers zero
      if (entering_sleep) begin
        pll_ctl <= 2'h0;
        clk_div <= {DIV_RST, DIV_RST};
      end else begin
        if (wr_pll) pll_ctl <= wm[1:0];
        if (wr_div) clk_div <= wm[15:0];
      end
      // Power-down also loses the PLL and the oscillator choice
      if (next_state == ST_WAKE) begin
        pll_ctl <= 2'h0;
        clk_src <= CLK_SRC_IRC;
      end
    end
  end

  // Sticky reset causes; a new cause beats a clearing write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      rst_cause <= 4'h0;
    else
      rst_cause <= (rst_cause & ~(wr_stat ? wm[5:2] : 4'h0)) | rst_src;
  end

  // AXI4-Lite slave: address and data taken in either order
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // Response once both halves are in
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // Readies computed from next held/answer flags so they leave flops;
      // one write and one read under way at a time
      s_axi_awready <= ~(do_write | aw_held | aw_take | b_stay);
      s_axi_wready  <= ~(do_write | w_held | w_take | b_stay);
      s_axi_arready <= ~(rd_take | (s_axi_rvalid & ~s_axi_rready));
    end
  end

  // Registered clock, power and reset outputs; gates, peripheral enables, pll_connect and chip_reset from the next state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gates          <= '0;
      periph_clk_en  <= '0;
      periph_clk_div <= '0;
      cpu_clk_div    <= DIV_RST;
      usb_clk_div    <= DIV_RST;
      pll_power      <= 1'b0;
      pll_connect    <= 1'b0;
      clk_src_sel    <= CLK_SRC_IRC;
      chip_reset     <= 1'b1;
      brownout_irq   <= 1'b0;
      vec_in_sram    <= 1'b0;
      rtc_alarm_out  <= 1'b0;
    end else begin
      // Core, memory and bus clocks only while running
      gates.cpu_clk    <= (next_state == ST_RUN);
      gates.mem_clk    <= (next_state == ST_RUN);
      gates.bus_clk    <= (next_state == ST_RUN);
      gates.periph_clk <= (next_state == ST_RUN) ||
                          (next_state == ST_IDLE);
      gates.main_osc   <= (next_state == ST_RUN) ||
                          (next_state == ST_IDLE) ||
                          (next_state == ST_RESET) ||
                          (next_state == ST_WAKE);
      gates.irc_out    <= ~(next_state inside
                            {ST_SLEEP, ST_PDOWN, ST_DPD});
      // RC stays powered in Sleep for a fast restart
      gates.irc_power  <= ~(next_state inside
                            {ST_PDOWN, ST_DPD});
      gates.rtc_osc    <= 1'b1;
      gates.pll_power  <= pll_ctl[PLL_EN_BIT] &
                          (next_state == ST_RUN);
      gates.flash_power <= (next_state != ST_DPD);
      gates.pin_hold   <= (next_state == ST_SLEEP);
      // Main domain off in deep power-down; battery domain untouched
      gates.core_power <= (next_state != ST_DPD);
      periph_clk_en    <= pclk_en[NPER-1:0] &
                          {NPER{(next_state == ST_RUN) ||
                                (next_state == ST_IDLE)}};
      periph_clk_div   <= pclk_div[2*NPER-1:0];
      cpu_clk_div      <= clk_div[7:0];
      usb_clk_div      <= clk_div[USB_DIV_LSB +: 8];
      pll_power        <= pll_ctl[PLL_EN_BIT] & ~in_reset;
      pll_connect      <= pll_ok & (next_state == ST_RUN);
      clk_src_sel      <= clk_src;
      chip_reset       <= (next_state == ST_RESET);
      brownout_irq     <= bod_stage1;
      vec_in_sram      <= memmap;
      rtc_alarm_out    <= rtc_alarm;
    end
  end

endmodule

// file: bench/pmc_ctrl_assertions.sv
// Port assertions for the power-mode and reset controller
module pmc_chk
  import pmc_pkg::*;
(
  // Clock and reset
  input logic       sys_clk,
  input logic       rst,
  // Watched inputs
  input logic       reset_pin_n,
  input logic       wdt_reset,
  input logic       por_reset,
  input logic       bod_stage1,
  input logic       bod_stage2,
  input logic       flash_init_done,
  input logic       pll_lock,
  // Watched outputs
  input pmc_gates_t gates,
  input logic       chip_reset,
  input logic       brownout_irq,
  input logic       pll_connect,
  input logic       vec_in_sram,
  input logic [1:0] clk_src_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Any source forces reset one edge later
  rst_merge_a:
    assert property ((wdt_reset || por_reset || !reset_pin_n)
      |=> chip_reset) else $error("reset source ignored");
  bod_reset_a:
    assert property (bod_stage2 |=> chip_reset)
      else $error("brownout reset missing");
  rst_hold_a:
    assert property (chip_reset && !flash_init_done |=> chip_reset)
      else $error("reset left before flash ready");
  // Level output, one register behind the detector
  bod_irq_a:
    assert property (!$past(rst) |-> brownout_irq == $past(bod_stage1))
      else $error("brownout irq off detector");
  pll_lock_a:
    assert property (pll_connect |-> $past(pll_lock))
      else $error("pll connected unlocked");
  // Two cycles of slack for registers behind the state
  rst_dflt_a:
    assert property (chip_reset [*3] |-> !vec_in_sram && !pll_connect
      && clk_src_sel == CLK_SRC_IRC) else $error("defaults lost");
  sleep_pll_a:
    assert property (gates.pin_hold |-> !pll_connect && !gates.pll_power)
      else $error("pll live while pins held");
  rtc_run_a:
    assert property (!$past(rst) |-> gates.rtc_osc)
      else $error("rtc oscillator stopped");
  cover property ($rose(gates.pin_hold));
  cover property ($rose(chip_reset) && wdt_reset);
  cover property ($fell(gates.cpu_clk) && gates.periph_clk);
endmodule

bind pmc_ctrl pmc_chk pmc_chk_i (.*);

// file: bench/pmc_far_model.sv
// Behavioural oscillator, PLL and flash beside the controller
module pmc_far_model
  import pmc_pkg::*;
(
  // Clock and reset
  input  logic       sys_clk,
  input  logic       rst,
  // Enables from the controller
  input  pmc_gates_t gates,
  input  logic       pll_power,
  // Readiness back to the controller
  output logic       main_osc_ok,
  output logic       pll_lock,
  output logic       flash_init_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] osc_sh, pll_sh, fl_sh;  // Start-up delay lines
  // Each source needs three cycles; losing its enable restarts it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {osc_sh, pll_sh, fl_sh} <= '0;
    end else begin
      osc_sh <= gates.main_osc ? {osc_sh[1:0], 1'b1} : 3'h0;
      pll_sh <= pll_power ? {pll_sh[1:0], 1'b1} : 3'h0;
      fl_sh <= gates.flash_power ? {fl_sh[1:0], 1'b1} : 3'h0;
    end
  end
  assign main_osc_ok = osc_sh[2];
  assign pll_lock = pll_sh[2];
  assign flash_init_done = fl_sh[2];
endmodule

// file: bench/testbench.sv
// Self-checking bench for the power-mode and reset controller
module testbench;
  import pmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Register bus
  logic        sys_clk, rst;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, periph_clk_div, q;
  logic [3:0]  s_axi_wstrb, src;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, clk_src_sel, r;
  // Power, reset and clock side
  logic        cpu_sleep_req, irq_pending, clockless_irq, rtc_irq;
  logic        reset_pin_n, wdt_reset, por_reset, bod_stage1, bod_stage2;
  logic        main_osc_ok, pll_lock, flash_init_done, rtc_alarm;
  logic        pll_power, pll_connect, chip_reset, brownout_irq;
  logic        vec_in_sram, rtc_alarm_out;
  logic [2:0]  wk;
  logic [15:0] periph_clk_en;
  logic [7:0]  cpu_clk_div, usb_clk_div;
  pmc_gates_t  gates;
  int          bad_count = 0, checks_done = 0, cyc = 0;

  assign s_axi_wstrb = 4'hf;  // Whole words only
  assign {bod_stage2, por_reset, wdt_reset} = src[3:1];
  assign reset_pin_n = !src[0];  // Pin is active low
  assign {clockless_irq, rtc_irq, irq_pending} = wk;

  // Short wake count keeps the run brief
  pmc_ctrl #(.WAKE_CNT(16'h0004)) pmc_ctrl_i (.*);
  pmc_far_model pmc_far_model_i (.*);

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the expected length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // One bus cycle; each channel drops valid at the edge it is taken
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic [1:0] rs);
    logic ao, wo, ar, tk;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    if (w) {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    else {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge sys_clk);
      ao = s_axi_awready;
      wo = s_axi_wready;
      ar = s_axi_arready;
      tk = w ? s_axi_bvalid : s_axi_rvalid;
      rs = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge sys_clk);
      if (ao) s_axi_awvalid <= 1'b0;
      if (wo) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end while (tk !== 1'b1);
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask

  // Select a mode, then request entry
  task automatic enter(input logic [1:0] m);
    bus(1'b1, ADDR_MODE, {30'h0, m}, q, r);
    @(negedge sys_clk);
    chk(gates.cpu_clk === 1'b1, "gated without request");
    @(posedge sys_clk);
    cpu_sleep_req <= 1'b1;
    @(posedge sys_clk);
    cpu_sleep_req <= 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic pulse(input logic [2:0] v);
    @(posedge sys_clk);
    wk <= v;
    @(posedge sys_clk);
    wk <= 3'h0;
  endtask

  task automatic t_regs();
    bus(1'b0, ADDR_PCLK_EN, 32'h0, q, r);
    chk(q === 32'hffffffff, "enables reset");
    bus(1'b1, ADDR_PCLK_EN, 32'h0000a5a5, q, r);
    chk(r === RESP_OKAY, "write answer");
    bus(1'b1, ADDR_PCLK_DIV, 32'h12345678, q, r);
    bus(1'b1, 8'h20, 32'h1, q, r);
    chk(r === RESP_SLVERR, "unmapped write");
    bus(1'b0, 8'h20, 32'h0, q, r);
    chk(r === RESP_SLVERR && q === 32'h0, "unmapped read");
    chk(periph_clk_en === 16'ha5a5, "enables");
    chk(periph_clk_div === 32'h12345678, "dividers");
    bus(1'b1, ADDR_MEMMAP, 32'h1, q, r);
    @(negedge sys_clk);
    chk(vec_in_sram === 1'b1, "vector map");
    $display("t_regs done");
  endtask

  task automatic t_idle();
    enter(MODE_IDLE);
    chk(gates[11:9] === 3'h0, "idle core clocks");
    chk(gates.periph_clk === 1'b1, "idle periph");
    pulse(3'h1);
    repeat (3) @(negedge sys_clk);
    chk(gates.cpu_clk === 1'b1, "idle wake");
    $display("t_idle done");
  endtask

  task automatic t_sleep();
    bus(1'b1, ADDR_PLL, 32'h3, q, r);
    @(negedge sys_clk);
    chk(pll_connect === 1'b0, "pll early");
    bus(1'b1, ADDR_CLK_DIV, 32'h0302, q, r);
    repeat (6) @(negedge sys_clk);
    chk(pll_connect === 1'b1 && cpu_clk_div === 8'h02, "pll on");
    enter(MODE_SLEEP);
    chk(gates === 12'h037, "sleep gates");
    chk({pll_connect, pll_power} === 2'h0, "sleep pll");
    chk({cpu_clk_div, usb_clk_div} === 16'h0, "sleep div");
    pulse(3'h1);
    repeat (3) @(negedge sys_clk);
    chk(gates.pin_hold === 1'b1, "clocked irq woke");
    pulse(3'h2);
    repeat (3) @(negedge sys_clk);
    chk(gates.cpu_clk === 1'b1 && !gates.pin_hold, "sleep wake");
    $display("t_sleep done");
  endtask

  task automatic t_pdown();
    for (logic [1:0] m = MODE_PDOWN; m != 2'h0; m++) begin
      bus(1'b1, ADDR_CLK_SRC, 32'h1, q, r);
      enter(m);
      chk(gates.cpu_clk === 1'b0 && !gates.main_osc, "pd gates");
      chk(gates.core_power === (m == MODE_PDOWN), "core");
      pulse(3'h4);
      repeat (2) @(negedge sys_clk);
      chk(gates.cpu_clk === 1'b0, "wake timer");
      repeat (12) @(negedge sys_clk);
      chk(gates.cpu_clk === 1'b1, "pd wake");
      chk(clk_src_sel === CLK_SRC_IRC, "wake source");
    end
    $display("t_pdown done");
  endtask

  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_STATUS, 32'h3c, q, r);
      @(posedge sys_clk);
      src <= 4'h1 << i;
      repeat (6) @(negedge sys_clk);
      chk(chip_reset === 1'b1, "reset merge");
      @(posedge sys_clk);
      src <= 4'h0;
      while (chip_reset !== 1'b0) @(negedge sys_clk);
      bus(1'b0, ADDR_STATUS, 32'h0, q, r);
      chk(q[5:2] === 4'h1 << i, "reset cause");
      bus(1'b0, ADDR_PCLK_EN, 32'h0, q, r);
      chk(q === 32'hffffffff && !vec_in_sram, "defaults");
    end
    $display("t_reset done");
  endtask

  task automatic t_bod();
    @(posedge sys_clk);
    bod_stage1 <= 1'b1;
    rtc_alarm <= 1'b1;
    bus(1'b0, ADDR_STATUS, 32'h0, q, r);
    chk(q[0] === 1'b1 && brownout_irq === 1'b1, "brownout");
    chk(rtc_alarm_out === 1'b1, "alarm");
    @(posedge sys_clk);
    bod_stage1 <= 1'b0;
    bus(1'b0, ADDR_STATUS, 32'h0, q, r);
    chk(q[0] === 1'b0 && brownout_irq === 1'b0, "recover");
    $display("t_bod done");
  endtask

  // Main sequence
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src, wk} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
    {s_axi_arvalid, s_axi_rready, cpu_sleep_req} <= 3'h0;
    {bod_stage1, rtc_alarm} <= 2'h0;
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    while (chip_reset !== 1'b0) @(negedge sys_clk);
    t_regs();
    t_idle();
    t_sleep();
    t_pdown();
    t_reset();
    t_bod();
    print_verdict();
  end
endmodule
